// file: aip_pa_protect.sv
`timescale 1ns/1ps
module aip_pa_protect (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Configuration and stimulus
  input wire aip_pkg::aip_pa_protect_cfg_t i_cfg,
  input wire logic [aip_pkg::NUM_ALARMS-1:0] i_alarms,
  input wire logic [aip_pkg::SMP_W-1:0] i_sample,
  // Results
  output logic [aip_pkg::SMP_W-1:0] o_sample,
  output logic [aip_pkg::GAIN_W-1:0] o_gain,
  output logic o_err
);
  typedef enum logic [1:0] {ST_IDLE, ST_DOWN, ST_HOLD, ST_UP} aip_pap_st_t;
  aip_pap_st_t st_ff;
  aip_pap_st_t nxt_st;
  logic [aip_pkg::SMP_W-1:0] good_ff;
  logic [aip_pkg::GAIN_W-1:0] gain_ff;
  logic [aip_pkg::GAIN_W-1:0] nxt_gain;
  logic [15:0] tmr_ff;
  logic err_ff;
  logic [aip_pkg::SMP_W-1:0] smp_ff;

  wire over_thr = i_sample > i_cfg.threshold;
  wire trig = i_cfg.enable && (over_thr || |(i_alarms & i_cfg.trig_sel));
  wire tick = (tmr_ff == 16'h0000);
  // Amplitude step equals step*i_sample/1024, i.e. gain step of step units of 1/1024.
  wire [aip_pkg::GAIN_W-1:0] up_g = {1'b0, i_cfg.ramp_up_step};
  wire [aip_pkg::GAIN_W-1:0] dn_g = {1'b0, i_cfg.ramp_down_step};
  wire [aip_pkg::SMP_W+aip_pkg::GAIN_W-1:0] scaled = i_sample * gain_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_gain = gain_ff;
    case (st_ff)
      ST_IDLE: if (trig) nxt_st = ST_DOWN;
      ST_DOWN: if (tick) begin
        if (gain_ff > dn_g) nxt_gain = gain_ff - dn_g;
        else begin
          nxt_gain = '0;
          nxt_st = ST_HOLD;
        end
      end
      ST_HOLD: if (!trig) nxt_st = ST_UP;
      ST_UP: if (trig) nxt_st = ST_DOWN;
        else if (tick) begin
          if (aip_pkg::GAIN_UNITY - gain_ff > up_g) nxt_gain = gain_ff + up_g;
          else begin
            nxt_gain = aip_pkg::GAIN_UNITY;
            nxt_st = ST_IDLE;
          end
        end
      default: nxt_st = ST_IDLE;
    endcase
    if (!i_cfg.enable) begin
      nxt_st = ST_IDLE;
      nxt_gain = aip_pkg::GAIN_UNITY;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= ST_IDLE;
      gain_ff <= aip_pkg::GAIN_UNITY;
      good_ff <= '0;
      tmr_ff <= '0;
      err_ff <= 1'b0;
      smp_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      gain_ff <= nxt_gain;
      if (st_ff == ST_IDLE && !trig) good_ff <= i_sample;
      // One amplitude step per programmed interval, never under one cycle.
      // The timer is rearmed while holding so a long hold cannot wrap it.
      if (st_ff == ST_IDLE || st_ff == ST_HOLD || tick)
        tmr_ff <= (i_cfg.ramp_step_time == 16'h0000) ? 16'h0000 :
          i_cfg.ramp_step_time - 16'h0001;
      else tmr_ff <= tmr_ff - 16'h0001;
      err_ff <= (nxt_st != ST_IDLE);
      smp_ff <= scaled[aip_pkg::SMP_W+aip_pkg::GAIN_SHIFT-1:aip_pkg::GAIN_SHIFT];
    end
  end

  assign o_sample = smp_ff;
  assign o_gain = gain_ff;
  assign o_err = err_ff;

  a_disabled_unity: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_cfg.enable |=> (gain_ff == aip_pkg::GAIN_UNITY) && !err_ff)
    else $error("gain not unity while protection disabled");
  a_trig_leaves_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (st_ff == ST_IDLE && trig) |=> st_ff == ST_DOWN)
    else $error("trigger did not start ramp down");
  a_down_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (st_ff == ST_DOWN && tick && i_cfg.enable && gain_ff > dn_g) |=>
    gain_ff == $past(gain_ff) - $past(dn_g))
    else $error("ramp down step wrong");
  a_up_bounded: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    gain_ff <= aip_pkg::GAIN_UNITY)
    else $error("gain above unity");
endmodule // aip_pa_protect

// file: aip_pkg.sv
package aip_pkg;

  // ------------------------------------------------------------
  // Alarm vector layout
  // ------------------------------------------------------------
  localparam int NUM_ALARMS = 11;
  localparam int ALM_JESD = 0;
  localparam int ALM_SPI = 1;
  localparam int ALM_PAP_A = 2;
  localparam int ALM_PLL0 = 6;
  localparam int NUM_PLL = 5;
  localparam int NUM_CH = 4;
  localparam int NUM_JESD_ERR = 13;
  localparam int NUM_IRQ = 2;
  localparam int IRQ_FIRST = 0;
  localparam int IRQ_SECOND = 1;

  // ------------------------------------------------------------
  // Protection datapath
  // ------------------------------------------------------------
  localparam int SMP_W = 16;
  localparam int STEP_W = 10;
  localparam int GAIN_W = 11;
  localparam int GAIN_SHIFT = 10;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 11'h400;
  localparam logic [STEP_W-1:0] STEP_TYP = 10'h01E;
  localparam logic [SMP_W-1:0] THR_TYP = 16'h2666;
  localparam logic [15:0] STEP_TIME_TYP = 16'h0002;
  localparam real CLK_PERIOD_NS = 25.0;
  localparam real STEP_TIME_NS = 5.0;
  localparam int STEP_CYC_MIN = (STEP_TIME_NS / CLK_PERIOD_NS) < 1.0 ? 1 :
                                int'(STEP_TIME_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic enable;
    logic [STEP_W-1:0] ramp_up_step;
    logic [STEP_W-1:0] ramp_down_step;
    logic [15:0] ramp_step_time;
    logic [SMP_W-1:0] threshold;
    logic [NUM_ALARMS-1:0] trig_sel;
  } aip_pa_protect_cfg_t;

endpackage

// file: aip_alarm_irq.sv
`timescale 1ns/1ps
module aip_alarm_irq (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Alarm sources
  input wire logic [aip_pkg::NUM_JESD_ERR-1:0] i_jesd_err,
  input wire logic i_spi_err,
  input wire logic [aip_pkg::NUM_PLL-1:0] i_pll_lol,
  // Interrupt routing configuration
  input wire logic [aip_pkg::NUM_IRQ-1:0][aip_pkg::NUM_ALARMS-1:0] i_irq_routing_cfg,
  // Protection configuration and transmit data
  input wire aip_pkg::aip_pa_protect_cfg_t [aip_pkg::NUM_CH-1:0] i_pa_protect_cfg,
  input wire logic [aip_pkg::NUM_CH-1:0][aip_pkg::SMP_W-1:0] i_tx_sample,
  // Outputs
  output logic o_irq_out_first,
  output logic o_irq_out_second,
  output logic [aip_pkg::NUM_CH-1:0][aip_pkg::SMP_W-1:0] o_tx_sample,
  output logic [aip_pkg::NUM_CH-1:0][aip_pkg::GAIN_W-1:0] o_tx_gain,
  output logic [aip_pkg::NUM_ALARMS-1:0] o_alarms
);
  // ------------------------------------------------------------
  // Alarm aggregation
  // ------------------------------------------------------------
  logic [aip_pkg::NUM_CH-1:0] pap_err;
  logic [aip_pkg::NUM_ALARMS-1:0] alarms_ff;
  logic [aip_pkg::NUM_IRQ-1:0] irq_ff;
  wire [aip_pkg::NUM_ALARMS-1:0] nxt_alarms = {i_pll_lol, pap_err, i_spi_err,
                                               |i_jesd_err};
  wire [aip_pkg::NUM_IRQ-1:0] nxt_irq;

  // Pins see the registered alarms, so a pin lags its source by two cycles.
  genvar p;
  generate
    for (p = 0; p < aip_pkg::NUM_IRQ; p++) begin : g_pin
      assign nxt_irq[p] = |(alarms_ff & i_irq_routing_cfg[p]);
    end
  endgenerate

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      alarms_ff <= '0;
      irq_ff <= '0;
    end else begin
      alarms_ff <= nxt_alarms;
      irq_ff <= nxt_irq;
    end
  end

  assign o_irq_out_first = irq_ff[aip_pkg::IRQ_FIRST];
  assign o_irq_out_second = irq_ff[aip_pkg::IRQ_SECOND];
  assign o_alarms = alarms_ff;

  // ------------------------------------------------------------
  // Per-channel amplifier protection
  // ------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < aip_pkg::NUM_CH; c++) begin : g_ch
      aip_pa_protect u_pap (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_cfg(i_pa_protect_cfg[c]),
        .i_alarms(alarms_ff),
        .i_sample(i_tx_sample[c]),
        .o_sample(o_tx_sample[c]),
        .o_gain(o_tx_gain[c]),
        .o_err(pap_err[c])
      );
    end
  endgenerate

  a_pin_first_or: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ##1 o_irq_out_first == $past(|(alarms_ff & i_irq_routing_cfg[0])))
    else $error("first pin not OR of routed alarms");
  a_pin_second_or: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ##1 o_irq_out_second == $past(|(alarms_ff & i_irq_routing_cfg[1])))
    else $error("second pin not OR of routed alarms");
  a_jesd_latency: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (|i_jesd_err) |=> o_alarms[aip_pkg::ALM_JESD])
    else $error("jesd error not flagged");
  a_spi_to_pin: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_spi_err && i_irq_routing_cfg[0][aip_pkg::ALM_SPI] && i_irq_routing_cfg[1][aip_pkg::ALM_SPI]
     ##1 i_irq_routing_cfg[0][aip_pkg::ALM_SPI] && i_irq_routing_cfg[1][aip_pkg::ALM_SPI])
    |=> o_irq_out_first && o_irq_out_second)
    else $error("spi alarm missing on both pins");
  a_pll_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ##1 o_alarms[aip_pkg::ALM_PLL0 +: aip_pkg::NUM_PLL] == $past(i_pll_lol))
    else $error("pll alarm mismatch");
endmodule // aip_alarm_irq

// file: aip_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side: counts rising edges seen on each interrupt pin
// ------------------------------------------------------------
module aip_host_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Interrupt pins
  input wire logic i_irq_out_first,
  input wire logic i_irq_out_second,
  // Edge counts
  output logic [1:0][7:0] o_edge_cnt
);
  logic [1:0] pin_ff;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_ff <= 2'h0;
      o_edge_cnt <= '0;
    end else begin
      pin_ff <= {i_irq_out_second, i_irq_out_first};
      if (i_irq_out_first && !pin_ff[0]) o_edge_cnt[0] <= o_edge_cnt[0] + 8'h01;
      if (i_irq_out_second && !pin_ff[1]) o_edge_cnt[1] <= o_edge_cnt[1] + 8'h01;
    end
  end
endmodule // aip_host_model

// file: alarm_irq_routing_pa_protect_test.sv
`timescale 1ns/1ps
module alarm_irq_routing_pa_protect_test;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [12:0] jesd = '0;
  logic spi = 1'b0;
  logic [4:0] pll = '0;
  logic [1:0][10:0] route = '0;
  aip_pkg::aip_pa_protect_cfg_t [3:0] pcfg = '0;
  logic [3:0][15:0] smp = '0;
  logic irq1, irq2;
  logic [3:0][15:0] osmp;
  logic [3:0][10:0] ogain;
  logic [10:0] alm;
  logic [1:0][7:0] edges;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] exp_edges [2] = '{8'h00, 8'h00};
  always #12.5 i_sys_clk = ~i_sys_clk;
  aip_alarm_irq dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_jesd_err(jesd), .i_spi_err(spi),
    .i_pll_lol(pll), .i_irq_routing_cfg(route), .i_pa_protect_cfg(pcfg), .i_tx_sample(smp),
    .o_irq_out_first(irq1), .o_irq_out_second(irq2), .o_tx_sample(osmp), .o_tx_gain(ogain),
    .o_alarms(alm));
  aip_host_model host_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_irq_out_first(irq1),
    .i_irq_out_second(irq2), .o_edge_cnt(edges));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // Waits for the channel gain to reach a target while timing every step after the first.
  task automatic ramp(input int ch, input logic [10:0] target);
    int n;
    int since;
    bit first;
    logic [10:0] prev;
    n = 0;
    since = 0;
    first = 1'b1;
    prev = ogain[ch];
    while (ogain[ch] !== target && n < 60) begin
      step(1);
      n++;
      since++;
      if (ogain[ch] !== prev) begin
        if (!first) chk(16'(since), 16'h0003);
        chk(16'(ogain[ch] & 11'h0FF), 16'h0000);
        first = 1'b0;
        since = 0;
        prev = ogain[ch];
      end
    end
    chk(16'(ogain[ch]), 16'(target));
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    int idx;
    logic f, s2;
    step(4);
    i_rst = 1'b0;
    chk(16'(ogain[2]), 16'h0400);
    // ------------------------------------------------------------
    // Routing: every source, pattern first only, second only, both
    // ------------------------------------------------------------
    for (int s = 0; s < 19; s++) begin
      idx = (s < 13) ? 0 : (s == 13) ? 1 : s - 8;
      f = (s % 3) != 1;
      s2 = (s % 3) != 0;
      route[0] = f ? (11'h001 << idx) : ~(11'h001 << idx);
      route[1] = s2 ? (11'h001 << idx) : ~(11'h001 << idx);
      if (s < 13) jesd[s] = 1'b1; else if (s == 13) spi = 1'b1; else pll[s - 14] = 1'b1;
      exp_edges[0] += 8'(f);
      exp_edges[1] += 8'(s2);
      step(1);
      chk(16'(alm), 16'(11'h001 << idx));
      chk(16'({irq2, irq1}), 16'h0000);
      step(1);
      chk(16'({irq2, irq1}), 16'({s2, f}));
      jesd = '0;
      spi = 1'b0;
      pll = '0;
      step(2);
      chk(16'({irq2, irq1}), 16'h0000);
    end
    chk(16'(edges[0]), 16'(exp_edges[0]));
    chk(16'(edges[1]), 16'(exp_edges[1]));
    // ------------------------------------------------------------
    // Protection: threshold trigger on channel C, alarm trigger on B
    // ------------------------------------------------------------
    route = '0;
    route[1][aip_pkg::ALM_PAP_A + 2] = 1'b1;
    for (int c = 1; c < 3; c++) begin
      pcfg[c] = '{enable: 1'b1, ramp_up_step: 10'h100, ramp_down_step: 10'h100,
        ramp_step_time: 16'h0003, threshold: aip_pkg::THR_TYP, trig_sel: 11'h000};
    end
    pcfg[1].trig_sel = 11'h002;
    smp = {16'h1000, 16'h1000, 16'h1000, 16'h1000};
    step(3);
    chk(osmp[2], 16'h1000);
    smp[2] = 16'h8000;
    smp[0] = 16'h8000;
    ramp(2, 11'h000);
    chk(16'(alm[aip_pkg::ALM_PAP_A + 2]), 16'h0001);
    chk(16'(irq2), 16'h0001);
    chk(16'(ogain[0]), 16'h0400);
    chk(16'(ogain[1]), 16'h0400);
    step(1);
    chk(osmp[2], 16'h0000);
    smp[2] = 16'h1000;
    ramp(2, 11'h400);
    step(3);
    chk(16'(alm[aip_pkg::ALM_PAP_A + 2]), 16'h0000);
    spi = 1'b1;
    ramp(1, 11'h000);
    spi = 1'b0;
    ramp(1, 11'h400);
    report_and_stop();
  end
endmodule // alarm_irq_routing_pa_protect_test
